// ### verilog/rtia_pkg.sv
package rtia_pkg;
  // Register byte addresses
  localparam logic [31:0] OFS_LABEL = 32'h0000006C;
  localparam logic [31:0] OFS_SELECT = 32'h00000070;
  localparam logic [31:0] OFS_EGRESS = 32'h00000074;
  // Reset values
  localparam logic [31:0] LABEL_RESET = 32'h00000000;
  localparam logic [7:0] SEL_BYTE_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  // Field layout, little-endian bit index (field bits 24:31 are [7:0])
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SEL_LO_LSB = 0;
  localparam int unsigned SEL_HI_LSB = 8;
  localparam int unsigned EGRESS_LSB = 0;
  // Switch geometry
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned PORT_W = 3;
  localparam logic [7:0] PORT_TOTAL = 8'h08;
  localparam logic [15:0] TABLE_SIZE_LIMIT = 16'h01FF;
  localparam int unsigned TABLE_DEPTH = 512;
  localparam int unsigned IDX_W = 9;
  localparam logic [7:0] UNMAPPED = 8'hFF;
  // AHB-Lite encodings
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {BUS_IDLE, BUS_DATA} rtia_bus_state_type;

  // A destination ID is checked against the size limit only in large mode; otherwise any ID is valid
  function automatic logic id_valid(input logic [15:0] id, input logic large_mode);
    return !large_mode || (id <= TABLE_SIZE_LIMIT);
  endfunction : id_valid

  // Any port value beyond the port count is stored as unmapped
  function automatic logic [7:0] encode_egress(input logic [7:0] value);
    return (value > PORT_TOTAL) ? UNMAPPED : value;
  endfunction : encode_egress
endpackage : rtia_pkg

// ### verilog/rtia_table.sv
`timescale 1ns/10ps
module rtia_table (
  input wire logic clk, // Register clock
  input wire logic wr_en, // Write strobe
  input wire logic [rtia_pkg::IDX_W-1:0] wr_idx, // Entry written
  input wire logic [7:0] wr_data, // Encoded egress port
  input wire logic [rtia_pkg::IDX_W-1:0] cfg_idx, // Entry read for software
  output logic [7:0] cfg_data, // Software read data, one cycle late
  input wire logic [rtia_pkg::IDX_W-1:0] lk_idx, // Entry read for routing
  output logic [7:0] lk_data // Routing read data, one cycle late
);
  // Entry contents are undefined until software writes them
  logic [7:0] mem [rtia_pkg::TABLE_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    cfg_data <= mem[cfg_idx];
    lk_data <= mem[lk_idx];
  end
endmodule : rtia_table

// ### verilog/rtia_ahb.sv
`timescale 1ns/10ps
module rtia_ahb (
  input wire logic clk, // Register clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  output logic acc_valid, // Data phase cycle of an accepted access of any size
  output logic acc_write, // Accepted access is a word write
  output logic [31:0] acc_addr, // Accepted address
  input wire logic [31:0] rd_data // Read value for acc_addr
);
  rtia_pkg::rtia_bus_state_type state_q;
  logic accept;
  logic write_q;
  logic [31:0] addr_q;

  assign accept = hsel && htrans[rtia_pkg::HTRANS_ACTIVE_BIT] && hready &&
                  (state_q == rtia_pkg::BUS_IDLE);
  assign acc_valid = (state_q == rtia_pkg::BUS_DATA);
  assign acc_write = write_q;
  assign acc_addr = addr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rtia_pkg::BUS_IDLE;
    end else begin
      unique case (state_q)
        rtia_pkg::BUS_IDLE: begin
          if (accept) begin
            state_q <= rtia_pkg::BUS_DATA;
          end
        end
        rtia_pkg::BUS_DATA: begin
          state_q <= rtia_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Every access takes one wait state so table reads can complete
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !accept;
    end
  end

  // Non-word writes are dropped here
  always_ff @(posedge clk) begin
    if (rst) begin
      write_q <= 1'b0;
      addr_q <= 32'h00000000;
    end else if (accept) begin
      write_q <= hwrite && (hsize == rtia_pkg::HSIZE_WORD);
      addr_q <= haddr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= rtia_pkg::RDATA_RESET;
    end else if (acc_valid && !write_q) begin
      hrdata <= rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hresp <= rtia_pkg::HRESP_OKAY;
    end else begin
      hresp <= rtia_pkg::HRESP_OKAY;
    end
  end
endmodule : rtia_ahb

// ### verilog/rtia_top.sv
`timescale 1ns/10ps
module rtia_top (
  input wire logic MCLK, // 125 MHz clock
  input wire logic RESET, // Synchronous reset, active high
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB byte address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic HREADYOUT, // AHB slave ready
  output logic HRESP, // AHB response
  output logic [31:0] HRDATA, // AHB read data
  input wire logic [rtia_pkg::NUM_PORTS-1:0] LARGE_LOOKUP_MODE, // Per-port size check on
  input wire logic [rtia_pkg::PORT_W-1:0] LOOKUP_INGRESS, // Port asking for a route
  input wire logic [15:0] LOOKUP_DESTID, // Destination ID to route
  output logic [7:0] LOOKUP_EGRESS, // Egress port or 0xFF
  output logic LOOKUP_MAPPED, // Route resolved to a port
  output logic [31:0] COMPONENT_LABEL // Label for port-write messages
);
  logic acc_valid;
  logic acc_write;
  logic [31:0] acc_addr;
  logic [31:0] rd_data;
  logic [31:0] label_q;
  logic [7:0] sel_lo_q;
  logic [7:0] sel_hi_q;
  logic [15:0] sel_id;
  logic sel_ok;
  logic table_wr;
  logic [7:0] port0_cfg;
  logic [7:0] lk_data [rtia_pkg::NUM_PORTS];
  logic [rtia_pkg::PORT_W-1:0] lk_port_q;
  logic lk_ok_q;
  logic [7:0] lk_sel;

  rtia_ahb u_ahb (
    .clk(MCLK),
    .rst(RESET),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .hrdata(HRDATA),
    .acc_valid(acc_valid),
    .acc_write(acc_write),
    .acc_addr(acc_addr),
    .rd_data(rd_data)
  );

  assign sel_id = {sel_hi_q, sel_lo_q};
  // The physical table ends at the size limit, so config access always checks it
  assign sel_ok = rtia_pkg::id_valid(sel_id, 1'b1);
  assign table_wr = acc_valid && acc_write && (acc_addr == rtia_pkg::OFS_EGRESS) && sel_ok;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      label_q <= rtia_pkg::LABEL_RESET;
    end else if (acc_valid && acc_write && (acc_addr == rtia_pkg::OFS_LABEL)) begin
      label_q <= HWDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      COMPONENT_LABEL <= rtia_pkg::LABEL_RESET;
    end else begin
      COMPONENT_LABEL <= label_q;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sel_lo_q <= rtia_pkg::SEL_BYTE_RESET;
      sel_hi_q <= rtia_pkg::SEL_BYTE_RESET;
    end else if (acc_valid && acc_write && (acc_addr == rtia_pkg::OFS_SELECT)) begin
      sel_lo_q <= HWDATA[rtia_pkg::SEL_LO_LSB +: rtia_pkg::BYTE_W];
      sel_hi_q <= HWDATA[rtia_pkg::SEL_HI_LSB +: rtia_pkg::BYTE_W];
    end
  end

  generate
    for (genvar p = 0; p < rtia_pkg::NUM_PORTS; p++) begin : g_port
      if (p == 0) begin : g_first
        rtia_table u_table (
          .clk(MCLK),
          .wr_en(table_wr),
          .wr_idx(sel_id[rtia_pkg::IDX_W-1:0]),
          .wr_data(rtia_pkg::encode_egress(HWDATA[rtia_pkg::EGRESS_LSB +: rtia_pkg::BYTE_W])),
          .cfg_idx(sel_id[rtia_pkg::IDX_W-1:0]),
          .cfg_data(port0_cfg),
          .lk_idx(LOOKUP_DESTID[rtia_pkg::IDX_W-1:0]),
          .lk_data(lk_data[p])
        );
      end else begin : g_other
        rtia_table u_table (
          .clk(MCLK),
          .wr_en(table_wr),
          .wr_idx(sel_id[rtia_pkg::IDX_W-1:0]),
          .wr_data(rtia_pkg::encode_egress(HWDATA[rtia_pkg::EGRESS_LSB +: rtia_pkg::BYTE_W])),
          .cfg_idx(sel_id[rtia_pkg::IDX_W-1:0]),
          .cfg_data(),
          .lk_idx(LOOKUP_DESTID[rtia_pkg::IDX_W-1:0]),
          .lk_data(lk_data[p])
        );
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h00000000;
    unique case (acc_addr)
      rtia_pkg::OFS_LABEL: begin
        rd_data = label_q;
      end
      rtia_pkg::OFS_SELECT: begin
        rd_data[rtia_pkg::SEL_LO_LSB +: rtia_pkg::BYTE_W] = sel_lo_q;
        rd_data[rtia_pkg::SEL_HI_LSB +: rtia_pkg::BYTE_W] = sel_hi_q;
      end
      rtia_pkg::OFS_EGRESS: begin
        // Stored entries already hold 0xFF when unmapped
        rd_data[rtia_pkg::EGRESS_LSB +: rtia_pkg::BYTE_W] =
            sel_ok ? port0_cfg : rtia_pkg::UNMAPPED;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  // Routing lookup: tables read in stage one, port picked in stage two
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lk_port_q <= '0;
      lk_ok_q <= 1'b0;
    end else begin
      lk_port_q <= LOOKUP_INGRESS;
      lk_ok_q <= rtia_pkg::id_valid(LOOKUP_DESTID, LARGE_LOOKUP_MODE[LOOKUP_INGRESS]);
    end
  end

  assign lk_sel = lk_ok_q ? lk_data[lk_port_q] : rtia_pkg::UNMAPPED;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      LOOKUP_EGRESS <= rtia_pkg::UNMAPPED;
      LOOKUP_MAPPED <= 1'b0;
    end else begin
      LOOKUP_EGRESS <= lk_sel;
      LOOKUP_MAPPED <= (lk_sel <= rtia_pkg::PORT_TOTAL);
    end
  end
endmodule : rtia_top

// ### test/rtia_asserts.sv
`timescale 1ns/10ps
module rtia_asserts (
  input wire logic MCLK, // Clock
  input wire logic RESET, // Reset
  input wire logic HSEL, // Select
  input wire logic [31:0] HADDR, // Address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write
  input wire logic [2:0] HSIZE, // Size
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  input wire logic HREADYOUT, // Slave ready
  input wire logic HRESP, // Response
  input wire logic [31:0] HRDATA, // Read data
  input wire logic [rtia_pkg::NUM_PORTS-1:0] LARGE_LOOKUP_MODE, // Size check
  input wire logic [rtia_pkg::PORT_W-1:0] LOOKUP_INGRESS, // Ingress port
  input wire logic [15:0] LOOKUP_DESTID, // Destination ID
  input wire logic [7:0] LOOKUP_EGRESS, // Egress port
  input wire logic LOOKUP_MAPPED, // Route mapped
  input wire logic [31:0] COMPONENT_LABEL // Label
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire acc = HSEL && HTRANS[1] && HREADY && HREADYOUT;
  property p_rst;
    disable iff (1'b0) RESET |=> HREADYOUT && !HRESP && HRDATA == 32'h0 &&
      LOOKUP_EGRESS == 8'hFF && !LOOKUP_MAPPED && COMPONENT_LABEL == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_okay; !HRESP; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_wait; acc |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  // Split in two directions so never-written table entries do not trip the check
  property p_mapped; LOOKUP_MAPPED |-> LOOKUP_EGRESS <= 8'h08; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped flag wrong");
  property p_port_mapped; LOOKUP_EGRESS <= 8'h08 |-> LOOKUP_MAPPED; endproperty
  a_port_mapped: assert property (p_port_mapped) else $error("mapped flag missing");
  property p_invalid;
    LARGE_LOOKUP_MODE[LOOKUP_INGRESS] && LOOKUP_DESTID > 16'h01FF |-> ##2 LOOKUP_EGRESS == 8'hFF;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid id routed");
  property p_label;
    acc && HWRITE && HSIZE == 3'h2 && HADDR == 32'h6C |=> ##2 COMPONENT_LABEL == $past(HWDATA, 2);
  endproperty
  a_label: assert property (p_label) else $error("label not updated");
  // Reset may clear the outputs at any time; only bus activity may move them otherwise
  property p_rdata; $changed(HRDATA) && !$past(RESET) |-> !$past(HREADYOUT); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_label_hold;
    $changed(COMPONENT_LABEL) && !$past(RESET) |-> !$past(HREADYOUT, 2);
  endproperty
  a_label_hold: assert property (p_label_hold) else $error("label moved");
endmodule : rtia_asserts

bind rtia_top rtia_asserts u_chk (.MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .LARGE_LOOKUP_MODE(LARGE_LOOKUP_MODE),
  .LOOKUP_INGRESS(LOOKUP_INGRESS), .LOOKUP_DESTID(LOOKUP_DESTID),
  .LOOKUP_EGRESS(LOOKUP_EGRESS), .LOOKUP_MAPPED(LOOKUP_MAPPED),
  .COMPONENT_LABEL(COMPONENT_LABEL));

// ### test/route_table_indirect_access_test.sv
`timescale 1ns/10ps
module route_table_indirect_access_test;
  logic MCLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, COMPONENT_LABEL, rd;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2, LOOKUP_INGRESS = 3'h0;
  logic [7:0] LARGE_LOOKUP_MODE = 8'hFF, LOOKUP_EGRESS;
  logic [15:0] LOOKUP_DESTID = 16'h0;
  logic HREADY, HREADYOUT, HRESP, LOOKUP_MAPPED;
  int n_mismatch = 0, compares = 0;
  assign HREADY = HREADYOUT;
  always #4 MCLK = ~MCLK;
  rtia_top uut (.MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .LARGE_LOOKUP_MODE(LARGE_LOOKUP_MODE),
    .LOOKUP_INGRESS(LOOKUP_INGRESS), .LOOKUP_DESTID(LOOKUP_DESTID),
    .LOOKUP_EGRESS(LOOKUP_EGRESS), .LOOKUP_MAPPED(LOOKUP_MAPPED),
    .COMPONENT_LABEL(COMPONENT_LABEL));
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Ready is stable from the falling edge up to the sampling rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'b1; HADDR <= a; HWRITE <= w; HTRANS <= 2'h2; HSIZE <= 3'h2;
    do @(negedge MCLK); while (HREADY !== 1'b1);
    @(posedge MCLK);
    HTRANS <= 2'h0; HWDATA <= d;
    do @(negedge MCLK); while (HREADY !== 1'b1);
    rd = HRDATA;
    @(posedge MCLK);
  endtask : xfer
  task rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc
  task look(input logic [2:0] p, input logic [15:0] id, input logic [7:0] exp);
    LOOKUP_INGRESS <= p; LOOKUP_DESTID <= id;
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    chk("lookup egress", {24'h0, exp}, {24'h0, LOOKUP_EGRESS});
    chk("lookup mapped", {31'h0, exp <= 8'h08}, {31'h0, LOOKUP_MAPPED});
    @(posedge MCLK);
  endtask : look
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    logic [7:0] vals [6];
    logic [7:0] e;
    vals = '{8'h00, 8'h03, 8'h08, 8'h09, 8'h7F, 8'hFF};
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    rdc("label", 32'h6C, 32'h0);
    rdc("select", 32'h70, 32'h0);
    xfer(1'b1, 32'h6C, 32'hA5C30F1E);
    rdc("label", 32'h6C, 32'hA5C30F1E);
    chk("label port", 32'hA5C30F1E, COMPONENT_LABEL);
    xfer(1'b1, 32'h70, 32'hFFFF0155);
    rdc("select", 32'h70, 32'h155);
    xfer(1'b1, 32'h74, 32'hFFFFFF05);
    rdc("egress", 32'h74, 32'h05);
    for (int p = 0; p < 8; p++) look(p[2:0], 16'h0155, 8'h05);
    for (int i = 0; i < 6; i++) begin
      e = (vals[i] > 8'h08) ? 8'hFF : vals[i];
      xfer(1'b1, 32'h70, 32'h100 + i);
      xfer(1'b1, 32'h74, {24'h0, vals[i]});
      rdc("egress", 32'h74, {24'h0, e});
      look(3'h7, 16'h100 + i[15:0], e);
    end
    LARGE_LOOKUP_MODE <= 8'hFE;
    look(3'h0, 16'h0301, 8'h03);
    LARGE_LOOKUP_MODE <= 8'hFF;
    look(3'h0, 16'h0301, 8'hFF);
    xfer(1'b1, 32'h70, 32'h0200);
    xfer(1'b1, 32'h74, 32'h3);
    rdc("egress", 32'h74, 32'hFF);
    xfer(1'b1, 32'h78, 32'h1234);
    rdc("unmapped", 32'h78, 32'h0);
    rdc("label", 32'h6C, 32'hA5C30F1E);
    RESET <= 1'b1;
    @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    rdc("label", 32'h6C, 32'h0);
    rdc("select", 32'h70, 32'h0);
    end_of_test();
  end
endmodule : route_table_indirect_access_test
